// ---- common/smsc_consts.svh ----
`ifndef SMSC_CONSTS_SVH
`define SMSC_CONSTS_SVH

// ==========================================================
// synchroniser depth for asynchronous request pins
`define SMSC_SYNC_STAGES 2
// number of pins passed through the synchroniser
`define SMSC_SYNC_WIDTH  4
// bit positions inside the synchroniser bundle
`define SMSC_BIT_MGMT    0
`define SMSC_BIT_STOP    1
`define SMSC_BIT_WBE     2
`define SMSC_BIT_BURST_READY_N    3
// level that every active-low pin settles to in reset
`define SMSC_PIN_IDLE    4'hF

`endif

// ---- common/smsc_pkg.sv ----
// ==========================================================
// sequencer states
package smsc_pkg;

  typedef enum logic [3:0] {
    SMSC_IDLE       = 4'b0000,
    SMSC_FLUSH      = 4'b0001,
    SMSC_DRAIN      = 4'b0010,
    SMSC_MGMT_ACK   = 4'b0011,
    SMSC_SAVE       = 4'b0100,
    SMSC_DIS_INT    = 4'b0101,
    SMSC_BRANCH     = 4'b0110,
    SMSC_MGMT_MODE  = 4'b0111,
    SMSC_SG_CYCLE   = 4'b1000,
    SMSC_STOP_GRANT = 4'b1001
  } smsc_state_t;

endpackage

// ---- hdl/smsc_sync.sv ----
`timescale 1ns/1ps
`include "smsc_consts.svh"

// ==========================================================
// multi-stage synchroniser, one chain per bit
module smsc_sync #(
  parameter int          WIDTH  = `SMSC_SYNC_WIDTH,
  parameter int          STAGES = `SMSC_SYNC_STAGES,
  parameter logic [WIDTH-1:0] INIT = `SMSC_PIN_IDLE
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [STAGES-1:0] chain;
      // first stage feeds only the next stage
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          chain <= {STAGES{INIT[g]}};
        end else begin
          chain <= {chain[STAGES-2:0], din[g]};
        end
      end
      assign dout[g] = chain[STAGES-1];
    end
  endgenerate

endmodule

// ---- hdl/smsc_seq.sv ----
`timescale 1ns/1ps
`include "smsc_consts.svh"

// Notes on behaviour
// - On a management request the pipelines are flushed, then all bus cycles finish.
// - The management-active acknowledge is given only after write-buffer-empty is seen.
// - With the write-buffer-empty input masked, the acknowledge does not wait for it.
// - After the acknowledge: save state, then disable interrupts, then branch to entry.
// - Management-active low tells system logic that management mode has been entered.
// - A stop-clock request leads to Stop Grant, where the internal clock is halted.
// - On a stop-clock request the pipelines are flushed, then all bus cycles finish.
// - The stop-clock request is acknowledged by a Stop Grant special bus cycle.
// - The clock halts only after burst-ready and write-buffer-empty were both seen.
// - With the write-buffer-empty input masked, Stop Grant entry ignores it.
// - System logic may stop the bus clock in Stop Grant, giving the Stop Clock state.
module smsc_seq (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic mgmt_mode_request_n,
  input  wire logic stop_clock_request_n,
  input  wire logic ext_write_buffer_empty_n,
  input  wire logic burst_ready_n,
  input  wire logic wbe_mask,
  input  wire logic pipe_flush_done,
  input  wire logic bus_cycles_idle,
  input  wire logic state_save_done,
  input  wire logic mgmt_mode_exit,
  output logic      mgmt_mode_active_n,
  output logic      pipe_flush_req,
  output logic      state_save_req,
  output logic      int_disable,
  output logic      branch_entry,
  output logic      stop_grant_cycle,
  output logic      internal_clock_en,
  output logic      stop_grant_state
);

  // ==========================================================
  // pin synchronisation
  logic [`SMSC_SYNC_WIDTH-1:0] pins_s;
  logic                        mgmt_n_s;
  logic                        stop_n_s;
  logic                        wbe_n_s;
  logic                        burst_ready_n_n_s;

  // minimum pulse widths of the requests make two stages enough
  smsc_sync #(
    .WIDTH  (`SMSC_SYNC_WIDTH),
    .STAGES (`SMSC_SYNC_STAGES),
    .INIT   (`SMSC_PIN_IDLE)
  ) u_sync (
    .clk    (clk),
    .rst_b  (rst_b),
    .din    ({burst_ready_n, ext_write_buffer_empty_n,
              stop_clock_request_n, mgmt_mode_request_n}),
    .dout   (pins_s)
  );

  assign mgmt_n_s = pins_s[`SMSC_BIT_MGMT];
  assign stop_n_s = pins_s[`SMSC_BIT_STOP];
  assign wbe_n_s  = pins_s[`SMSC_BIT_WBE];
  assign burst_ready_n_n_s = pins_s[`SMSC_BIT_BURST_READY_N];

  // ==========================================================
  // management request edge capture
  logic mgmt_prev;
  logic mgmt_pend;
  logic mgmt_fall;
  logic mgmt_take;

  assign mgmt_fall = mgmt_prev & ~mgmt_n_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_prev <= 1'b1;
    end else begin
      mgmt_prev <= mgmt_n_s;
    end
  end

  // a new edge in the cycle it is taken stays pending
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_pend <= 1'b0;
    end else if (mgmt_fall) begin
      mgmt_pend <= 1'b1;
    end else if (mgmt_take) begin
      mgmt_pend <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  smsc_pkg::smsc_state_t state;
  smsc_pkg::smsc_state_t next_state;
  logic                  serving_stop;
  logic                  burst_ready_n_seen;
  logic                  wbe_seen;
  logic                  next_burst_ready_n_seen;
  logic                  next_wbe_seen;
  logic                  wbe_ok;

  assign wbe_ok = ~wbe_n_s | wbe_mask;

  always_comb begin
    next_state     = state;
    mgmt_take      = 1'b0;
    next_burst_ready_n_seen = 1'b0;
    next_wbe_seen  = 1'b0;
    unique case (state)
      smsc_pkg::SMSC_IDLE: begin
        // management request outranks stop clock
        if (mgmt_pend) begin
          next_state = smsc_pkg::SMSC_FLUSH;
          mgmt_take  = 1'b1;
        end else if (!stop_n_s) begin
          next_state = smsc_pkg::SMSC_FLUSH;
        end
      end
      smsc_pkg::SMSC_FLUSH: begin
        if (pipe_flush_done) begin
          next_state = smsc_pkg::SMSC_DRAIN;
        end
      end
      smsc_pkg::SMSC_DRAIN: begin
        if (bus_cycles_idle) begin
          next_state = serving_stop ? smsc_pkg::SMSC_SG_CYCLE
                                    : smsc_pkg::SMSC_MGMT_ACK;
        end
      end
      smsc_pkg::SMSC_MGMT_ACK: begin
        if (wbe_ok) begin
          next_state = smsc_pkg::SMSC_SAVE;
        end
      end
      smsc_pkg::SMSC_SAVE: begin
        if (state_save_done) begin
          next_state = smsc_pkg::SMSC_DIS_INT;
        end
      end
      smsc_pkg::SMSC_DIS_INT: begin
        next_state = smsc_pkg::SMSC_BRANCH;
      end
      smsc_pkg::SMSC_BRANCH: begin
        next_state = smsc_pkg::SMSC_MGMT_MODE;
      end
      smsc_pkg::SMSC_MGMT_MODE: begin
        if (mgmt_mode_exit) begin
          next_state = smsc_pkg::SMSC_IDLE;
        end
      end
      smsc_pkg::SMSC_SG_CYCLE: begin
        next_burst_ready_n_seen = burst_ready_n_seen | ~burst_ready_n_n_s;
        next_wbe_seen  = wbe_seen | wbe_ok;
        if (next_burst_ready_n_seen && next_wbe_seen) begin
          next_state = smsc_pkg::SMSC_STOP_GRANT;
        end
      end
      smsc_pkg::SMSC_STOP_GRANT: begin
        // a stopped bus clock simply freezes us here
        if (stop_n_s) begin
          next_state = smsc_pkg::SMSC_IDLE;
        end
      end
      default: begin
        next_state = smsc_pkg::SMSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= smsc_pkg::SMSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serving_stop <= 1'b0;
    end else if (state == smsc_pkg::SMSC_IDLE) begin
      serving_stop <= ~mgmt_pend & ~stop_n_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_ready_n_seen <= 1'b0;
      wbe_seen  <= 1'b0;
    end else begin
      burst_ready_n_seen <= next_burst_ready_n_seen;
      wbe_seen  <= next_wbe_seen;
    end
  end

  // ==========================================================
  // registered outputs, aligned with the state they belong to
  logic next_in_mgmt;

  assign next_in_mgmt = (next_state == smsc_pkg::SMSC_SAVE)
                      | (next_state == smsc_pkg::SMSC_DIS_INT)
                      | (next_state == smsc_pkg::SMSC_BRANCH)
                      | (next_state == smsc_pkg::SMSC_MGMT_MODE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_mode_active_n <= 1'b1;
      state_save_req     <= 1'b0;
      int_disable        <= 1'b0;
      branch_entry       <= 1'b0;
    end else begin
      mgmt_mode_active_n <= ~next_in_mgmt;
      state_save_req     <= next_state == smsc_pkg::SMSC_SAVE;
      int_disable        <= next_in_mgmt & (next_state != smsc_pkg::SMSC_SAVE);
      branch_entry       <= next_state == smsc_pkg::SMSC_BRANCH;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pipe_flush_req    <= 1'b0;
      stop_grant_cycle  <= 1'b0;
      internal_clock_en <= 1'b1;
      stop_grant_state  <= 1'b0;
    end else begin
      pipe_flush_req    <= next_state == smsc_pkg::SMSC_FLUSH;
      // the special cycle ends on burst-ready even if the buffer is still draining
      stop_grant_cycle  <= (next_state == smsc_pkg::SMSC_SG_CYCLE) & ~next_burst_ready_n_seen;
      internal_clock_en <= next_state != smsc_pkg::SMSC_STOP_GRANT;
      stop_grant_state  <= next_state == smsc_pkg::SMSC_STOP_GRANT;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_flush_before_drain;
    (state == smsc_pkg::SMSC_DRAIN) |-> $past(state == smsc_pkg::SMSC_FLUSH)
      || $past(state == smsc_pkg::SMSC_DRAIN);
  endproperty
  a_flush_before_drain: assert property (p_flush_before_drain)
    else $error("drain entered without flush");

  property p_ack_needs_wbe;
    $fell(mgmt_mode_active_n) |-> $past(!wbe_n_s || wbe_mask)
      && $past(state == smsc_pkg::SMSC_MGMT_ACK);
  endproperty
  a_ack_needs_wbe: assert property (p_ack_needs_wbe)
    else $error("acknowledge without write buffer empty");

  property p_mask_ack;
    (state == smsc_pkg::SMSC_MGMT_ACK && wbe_mask) |=> !mgmt_mode_active_n;
  endproperty
  a_mask_ack: assert property (p_mask_ack)
    else $error("masked acknowledge delayed");

  property p_save_order;
    (state == smsc_pkg::SMSC_SAVE && state_save_done)
      |=> (int_disable && !branch_entry) ##1 (int_disable && branch_entry);
  endproperty
  a_save_order: assert property (p_save_order)
    else $error("save, disable, branch order broken");

  property p_active_in_mode;
    (state == smsc_pkg::SMSC_MGMT_MODE) |-> !mgmt_mode_active_n && !pipe_flush_req;
  endproperty
  a_active_in_mode: assert property (p_active_in_mode)
    else $error("management active lost in management mode");

  property p_sg_cycle_start;
    (state == smsc_pkg::SMSC_DRAIN && serving_stop && bus_cycles_idle)
      |=> stop_grant_cycle && mgmt_mode_active_n;
  endproperty
  a_sg_cycle_start: assert property (p_sg_cycle_start)
    else $error("stop grant cycle not started");

  property p_halt_cond;
    $fell(internal_clock_en) |-> $past(burst_ready_n_seen || !burst_ready_n_n_s)
      && $past(wbe_seen || wbe_ok) && stop_grant_state;
  endproperty
  a_halt_cond: assert property (p_halt_cond)
    else $error("clock halted too early");

  property p_restart;
    (state == smsc_pkg::SMSC_STOP_GRANT && stop_n_s) |=> internal_clock_en && !stop_grant_state;
  endproperty
  a_restart: assert property (p_restart)
    else $error("clock not restarted");

  c_mgmt_entered: cover property ($fell(mgmt_mode_active_n));
  c_mgmt_masked:  cover property (state == smsc_pkg::SMSC_MGMT_ACK && wbe_mask && wbe_n_s);
  c_stop_grant:   cover property ($fell(internal_clock_en));
  c_sg_resume:    cover property ($rose(internal_clock_en));

endmodule

// ---- tb/smsc_sysl_model.sv ----
`timescale 1ns/1ps

// ==========================================================
// system logic side: burst ready and write buffer empty pins
module smsc_sysl_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       stop_grant_cycle,
  input  wire logic       wbe_busy,
  input  wire logic [3:0] burst_ready_n_delay,
  output logic            burst_ready_n,
  output logic            ext_write_buffer_empty_n
);
  logic [3:0] wait_cnt;

  initial begin
    burst_ready_n = 1'b1;
    ext_write_buffer_empty_n = 1'b1;
    wait_cnt = 4'h0;
  end

  // pins move just after the edge, like any synchronous driver
  always @(posedge clk) begin
    #1;
    ext_write_buffer_empty_n = wbe_busy | ~rst_b;
    if (!rst_b || !stop_grant_cycle) begin
      wait_cnt = 4'h0;
    end else if (wait_cnt < burst_ready_n_delay) begin
      wait_cnt = wait_cnt + 4'h1;
    end
    // held low until the special cycle closes, then back to idle high
    burst_ready_n = ~(rst_b & stop_grant_cycle & (wait_cnt == burst_ready_n_delay));
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

// ==========================================================
// sequencer testbench
module tb_top;
  logic       clk, rst_b, clk_run, wbe_busy;
  logic       mgmt_mode_request_n, stop_clock_request_n, wbe_mask;
  logic       pipe_flush_done, bus_cycles_idle, state_save_done, mgmt_mode_exit;
  logic [3:0] burst_ready_n_delay;
  logic       burst_ready_n, ext_write_buffer_empty_n;
  logic       mgmt_mode_active_n, pipe_flush_req, state_save_req, int_disable;
  logic       branch_entry, stop_grant_cycle, internal_clock_en, stop_grant_state;
  logic [7:0] obs;
  int         bad_count, check_count;
  localparam int ACT = 0, FLU = 1, SGC = 5, CKE = 6, SGS = 7;

  assign obs = {stop_grant_state, internal_clock_en, stop_grant_cycle, branch_entry,
                int_disable, state_save_req, pipe_flush_req, mgmt_mode_active_n};

  smsc_seq smsc_seq_inst (.clk(clk), .rst_b(rst_b), .mgmt_mode_request_n(mgmt_mode_request_n),
    .stop_clock_request_n(stop_clock_request_n), .wbe_mask(wbe_mask),
    .ext_write_buffer_empty_n(ext_write_buffer_empty_n), .burst_ready_n(burst_ready_n),
    .pipe_flush_done(pipe_flush_done), .bus_cycles_idle(bus_cycles_idle),
    .state_save_done(state_save_done), .mgmt_mode_exit(mgmt_mode_exit),
    .mgmt_mode_active_n(mgmt_mode_active_n), .pipe_flush_req(pipe_flush_req),
    .state_save_req(state_save_req), .int_disable(int_disable), .branch_entry(branch_entry),
    .stop_grant_cycle(stop_grant_cycle), .internal_clock_en(internal_clock_en),
    .stop_grant_state(stop_grant_state));

  smsc_sysl_model smsc_sysl_model_inst (.clk(clk), .rst_b(rst_b),
    .stop_grant_cycle(stop_grant_cycle), .wbe_busy(wbe_busy), .burst_ready_n_delay(burst_ready_n_delay),
    .burst_ready_n(burst_ready_n), .ext_write_buffer_empty_n(ext_write_buffer_empty_n));

  // ==========================================================
  // clock, gated so the bus clock can be stopped in stop grant
  initial begin
    clk = 1'b0;
    clk_run = 1'b1;
    forever begin
      #2;
      if (clk_run) clk = ~clk;
    end
  end

  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait on one observed output
  task automatic wait_on(input string name, input int idx, input logic val, input int max);
    for (int n = 0; n < max && obs[idx] !== val; n++) step(1);
    chk(name, {7'h00, val}, {7'h00, obs[idx]});
  endtask

  // flush, then bus cycles still busy: no acknowledge may appear yet
  task automatic core_step();
    wait_on("flush_req", FLU, 1'b1, 8);
    pipe_flush_done = 1'b1;
    step(1);
    pipe_flush_done = 1'b0;
    step(4);
    chk("ack_before_idle", 8'h41, obs);
    bus_cycles_idle = 1'b1;
  endtask

  // ==========================================================
  // scenarios
  task automatic mgmt_entry(input logic mask);
    wbe_busy = 1'b1;
    wbe_mask = mask;
    mgmt_mode_request_n = 1'b0;
    step(4);
    mgmt_mode_request_n = 1'b1;
    core_step();
    step(6);
    chk("ack_wbe_gate", {7'h00, ~mask}, {7'h00, mgmt_mode_active_n});
    wbe_busy = 1'b0;
    wait_on("mgmt_active", ACT, 1'b0, 6);
    step(3);
    chk("saving", 8'h44, obs);
    state_save_done = 1'b1;
    step(1);
    state_save_done = 1'b0;
    chk("int_off", 8'h48, obs);
    step(1);
    chk("branch", 8'h58, obs);
    step(6);
    chk("in_mgmt", 8'h48, obs);
    mgmt_mode_exit = 1'b1;
    step(1);
    mgmt_mode_exit = 1'b0;
    chk("mgmt_exit", 8'h41, obs);
    bus_cycles_idle = 1'b0;
    step(4);
  endtask

  task automatic stop_entry(input logic mask, input logic [3:0] delay);
    wbe_busy = 1'b1;
    wbe_mask = mask;
    burst_ready_n_delay = delay;
    stop_clock_request_n = 1'b0;
    core_step();
    wait_on("sg_cycle", SGC, 1'b1, 6);
    step(1);
    chk("sg_wait_burst_ready_n", 8'h61, obs);
    wait_on("sg_cycle_end", SGC, 1'b0, 12);
    step(4);
    chk("sg_wbe_gate", mask ? 8'h81 : 8'h41, obs);
    wbe_busy = 1'b0;
    wait_on("stop_grant", SGS, 1'b1, 6);
    chk("clock_halted", 8'h81, obs);
    clk_run = 1'b0;
    #40;
    clk_run = 1'b1;
    step(3);
    chk("stop_clock", 8'h81, obs);
    stop_clock_request_n = 1'b1;
    wait_on("clock_back", CKE, 1'b1, 6);
    chk("resumed", 8'h41, obs);
    bus_cycles_idle = 1'b0;
    step(4);
  endtask

  // management edge latched in the same clock that stop-clock reaches the sequencer is served first
  task automatic mgmt_then_stop();
    wbe_busy = 1'b0;
    wbe_mask = 1'b0;
    mgmt_mode_request_n = 1'b0;
    step(1);
    stop_clock_request_n = 1'b0;
    step(3);
    mgmt_mode_request_n = 1'b1;
    core_step();
    step(2);
    chk("mgmt_first", 8'h44, obs);
    state_save_done = 1'b1;
    step(1);
    state_save_done = 1'b0;
    step(2);
    mgmt_mode_exit = 1'b1;
    bus_cycles_idle = 1'b0;
    step(1);
    mgmt_mode_exit = 1'b0;
    chk("mgmt_left", 8'h41, obs);
    core_step();
    wait_on("late_sg_cycle", SGC, 1'b1, 6);
    wait_on("late_stop_grant", SGS, 1'b1, 8);
    stop_clock_request_n = 1'b1;
    wait_on("late_resume", CKE, 1'b1, 6);
    bus_cycles_idle = 1'b0;
    step(4);
  endtask

  // ==========================================================
  // run control
  task automatic complete_run();
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end

  initial begin
    bad_count = 0;
    check_count = 0;
    rst_b = 1'b0;
    mgmt_mode_request_n = 1'b1;
    stop_clock_request_n = 1'b1;
    wbe_mask = 1'b0;
    wbe_busy = 1'b1;
    burst_ready_n_delay = 4'h0;
    pipe_flush_done = 1'b0;
    bus_cycles_idle = 1'b0;
    state_save_done = 1'b0;
    mgmt_mode_exit = 1'b0;
    step(20);
    chk("in_reset", 8'h41, obs);
    rst_b = 1'b1;
    step(3);
    chk("after_reset", 8'h41, obs);
    mgmt_entry(1'b0);
    mgmt_entry(1'b1);
    stop_entry(1'b0, 4'h3);
    stop_entry(1'b1, 4'h0);
    mgmt_then_stop();
    complete_run();
  end
endmodule
